// File: core/piw_regs.vh
/*
  Constants for the priority interrupt and wake-up unit: register offsets,
  field positions, reset values, level codes and filter timing counts.
  Assumes it is included by bare name from the unit's design file.
*/
// ==========================================================================
// Overview of operation
// - Three levels: highest above high above low
// - Block requests at or below in-service level
// - Simultaneous requests: highest level granted first
// - Equal levels: lowest vector address wins
// - Twenty-nine sources share ten vector addresses
// - Halt stops core; ends on reset/interrupt
// - Deep hold stops core, peripherals, all oscillators
// - Deep hold wakes: reset pin, pins, port zero
// - Crystal hold keeps base timer and crystal
// - Crystal hold also wakes on base timer
// - Filter constant one, thirty-two or 128 cycles
// - Pin read returns raw level, not filtered
`ifndef PIW_REGS_VH
`define PIW_REGS_VH

// ==========================================================================
// Register offsets (byte addresses)
`define PIW_OFS_PEND 8'h00
`define PIW_OFS_ENABLE 8'h04
`define PIW_OFS_LEVEL 8'h08
`define PIW_OFS_STANDBY 8'h0c
`define PIW_OFS_FILTER 8'h10
`define PIW_OFS_WAKEPOL 8'h14
`define PIW_OFS_STATUS 8'h18

// ==========================================================================
// Field positions
`define PIW_FLT_SEL_LSB 0
`define PIW_FLT_EN_BIT 2
`define PIW_FLT_RAW_BIT 8
`define PIW_ST_INSVC_LSB 0
`define PIW_ST_MODE_LSB 4
`define PIW_ST_FILT_BIT 8

// ==========================================================================
// Reset values
`define PIW_RST_ENABLE 29'h0000000
`define PIW_RST_LEVEL 10'h000
`define PIW_RST_FILTER 3'h0
`define PIW_RST_WAKEPOL 5'h00

// ==========================================================================
// Source indices of the filtered pin and of wake-relevant sources
`define PIW_SRC_FILT 5
`define PIW_SRC_BT0 7
`define PIW_SRC_BT1 8
`define PIW_SRC_PORT0 25

// ==========================================================================
// Levels, standby modes, vector address layout
`define PIW_LVL_NONE 2'h0
`define PIW_LVL_LOW 2'h1
`define PIW_LVL_HIGH 2'h2
`define PIW_LVL_TOP 2'h3
`define PIW_MODE_RUN 2'h0
`define PIW_MODE_HALT 2'h1
`define PIW_MODE_HOLD 2'h2
`define PIW_MODE_XHOLD 2'h3
`define PIW_VEC_BASE 20'h00003
`define PIW_VEC_STEP 20'h00008

// ==========================================================================
// Filter timing in core clocks; one instruction cycle is one clock,
// so the counts equal the selectable time constants
`define PIW_FLT_CYC0 8'h01
`define PIW_FLT_CYC1 8'h20
`define PIW_FLT_CYC2 8'h80

`endif

// File: core/piw_top.v
/*
  Priority interrupt and wake-up unit: pending flags for 29 sources,
  ten shared vectors, three-level nesting arbitration, standby mode
  control with wake-up, and a noise filter on one external pin.
  Assumes peripheral request pulses arrive on core_clk, pins arrive
  asynchronously, and the core acknowledges and returns from service.
*/
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ns
`include "piw_regs.vh"

module piw_top (
  input wire core_clk,            // System clock, 25 MHz
  input wire sys_rst,             // Synchronous reset, active high
  input wire [7:0] reg_addr,      // Register byte address
  input wire [31:0] reg_wdata,    // Register write data
  input wire reg_wr,              // Write strobe
  input wire reg_rd,              // Read strobe
  output reg [31:0] reg_rdata,    // Read data, cycle after strobe
  input wire [28:0] src_req,      // Peripheral request pulses
  input wire [4:0] wake_pin,      // Pins a, b, c, e, f (async)
  input wire filtered_ext_irq_pin, // Noisy shared pin (async)
  input wire rst_pin_n,           // Reset pin level (async)
  input wire irq_ack,             // Core takes the offered vector
  input wire irq_ret,             // Core returns from service
  output reg irq_req,             // Vector offered to the core
  output reg [19:0] irq_addr,     // Vector entry address
  output reg [1:0] irq_lvl,       // Level of the offered vector
  output reg filt_out,            // Filtered pin level
  output reg cpu_stop,            // Instruction execution halted
  output reg periph_stop,         // Peripherals suspended
  output reg bt_stop,             // Base timer suspended
  output reg osc_main_stop,       // Ceramic and RC oscillators off
  output reg osc_xtal_stop        // Crystal oscillator off
);

  // ========================================================================
  // Declarations
  reg [28:0] pend_r;              // Sticky source flags
  reg [28:0] pend_nxt;
  reg [28:0] en_r;                // Source enables
  reg [9:0] lvl_r;                // Per vector: 1 raises level
  reg [2:0] flt_r;                // Filter select and enable
  reg [4:0] wpol_r;               // Wake pin level: 1 = high
  reg [1:0] mode_r;               // Standby mode
  reg [2:0] insvc_r;              // In-service bit per level
  reg [4:0] wk_s1_r;              // Wake pin first stage
  reg [4:0] wk_s2_r;
  reg fp_s1_r;                    // Filtered pin first stage
  reg fp_s2_r;
  reg rp_s1_r;                    // Reset pin first stage
  reg rp_s2_r;
  reg [7:0] fcnt_r;               // Filter stability count
  reg filt_d_r;                   // Filter output, previous cycle
  wire [9:0] vreq;                // Vector has an enabled request
  reg [1:0] cur_lvl;              // Level now in service
  reg [1:0] best_lvl;
  reg [3:0] best_vec;
  reg [1:0] vl;
  reg [7:0] flt_lim;
  reg [1:0] mode_nxt;
  reg wake_hold;
  reg wake_x;
  wire grant_ok;
  wire [28:0] src_all;
  integer i;

  // ========================================================================
  // Source to vector map
  // Returns a mask of the sources that share vector v.
  function [28:0] vmask;
    input [3:0] v;
    begin
      case (v)
        4'h0: vmask = 29'h0000001;
        4'h1: vmask = 29'h0000002;
        4'h2: vmask = 29'h000001c;
        4'h3: vmask = 29'h00001e0;
        4'h4: vmask = 29'h0000600;
        4'h5: vmask = 29'h0003800;
        4'h6: vmask = 29'h001c000;
        4'h7: vmask = 29'h00e0000;
        4'h8: vmask = 29'h1f00000 & 29'h1ffffff;
        default: vmask = 29'h1e000000 >> 0;
      endcase
    end
  endfunction

  // One OR per vector over its enabled pending sources
  genvar gv;
  generate
    for (gv = 0; gv < 10; gv = gv + 1) begin : g_vec
      localparam [3:0] VIDX = gv; // Vector index at the map's width
      assign vreq[gv] = |(pend_r & en_r & vmask(VIDX));
    end
  endgenerate

  // ========================================================================
  // Pin synchronisers
  // Each pin passes two flops; only the second stage is read.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      wk_s1_r <= 5'h00;
      wk_s2_r <= 5'h00;
      fp_s1_r <= 1'b0;
      fp_s2_r <= 1'b0;
      rp_s1_r <= 1'b1;
      rp_s2_r <= 1'b1;
    end else begin
      wk_s1_r <= wake_pin;
      wk_s2_r <= wk_s1_r;
      fp_s1_r <= filtered_ext_irq_pin;
      fp_s2_r <= fp_s1_r;
      rp_s1_r <= rst_pin_n;
      rp_s2_r <= rp_s1_r;
    end
  end

  // ========================================================================
  // Noise filter
  // Output follows the pin only after it has stayed changed for the
  // selected time; when disabled the shortest constant applies.
  always @* begin
    if (!flt_r[`PIW_FLT_EN_BIT])
      flt_lim = 8'h01;
    else if (flt_r[1:0] == 2'h1)
      flt_lim = `PIW_FLT_CYC1;
    else if (flt_r[1:0] == 2'h2)
      flt_lim = `PIW_FLT_CYC2;
    else
      flt_lim = `PIW_FLT_CYC0;
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      fcnt_r <= 8'h00;
      filt_out <= 1'b0;
      filt_d_r <= 1'b0;
    end else begin
      filt_d_r <= filt_out;
      if (fp_s2_r == filt_out) begin
        // Stable at the output level: restart the count
        fcnt_r <= 8'h00;
      end else if (fcnt_r + 8'h01 >= flt_lim) begin
        filt_out <= fp_s2_r;
        fcnt_r <= 8'h00;
      end else begin
        fcnt_r <= fcnt_r + 8'h01;
      end
    end
  end

  // Rising edge of the filtered pin joins its shared source
  assign src_all = src_req |
    ({28'h0000000, filt_out & ~filt_d_r} << `PIW_SRC_FILT);

  // ========================================================================
  // Arbitration
  // Level now in service is the highest in-service bit.
  always @* begin
    if (insvc_r[2])
      cur_lvl = `PIW_LVL_TOP;
    else if (insvc_r[1])
      cur_lvl = `PIW_LVL_HIGH;
    else if (insvc_r[0])
      cur_lvl = `PIW_LVL_LOW;
    else
      cur_lvl = `PIW_LVL_NONE;
  end

  // Scan from the top vector down so that a tie leaves the lowest
  // vector address standing.
  always @* begin
    best_lvl = `PIW_LVL_NONE;
    best_vec = 4'h0;
    vl = `PIW_LVL_NONE;
    for (i = 9; i >= 0; i = i - 1) begin
      if (!lvl_r[i])
        vl = `PIW_LVL_LOW;
      else if (i < 2)
        vl = `PIW_LVL_TOP;
      else
        vl = `PIW_LVL_HIGH;
      if (vreq[i] && vl >= best_lvl) begin
        best_lvl = vl;
        best_vec = i[3:0];
      end
    end
  end

  // Only strictly higher levels may nest
  assign grant_ok = (best_lvl != `PIW_LVL_NONE) &&
                    (best_lvl > cur_lvl);

  // ========================================================================
  // Offer to the core and in-service tracking
  // The offer is withdrawn in the cycle after acknowledge so that the
  // same vector is not taken twice.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      irq_req <= 1'b0;
      irq_addr <= `PIW_VEC_BASE;
      irq_lvl <= `PIW_LVL_NONE;
      insvc_r <= 3'h0;
    end else begin
      if (irq_ack && irq_req) begin
        irq_req <= 1'b0;
      end else begin
        irq_req <= grant_ok;
        irq_addr <= `PIW_VEC_BASE +
                    ({16'h0000, best_vec} * `PIW_VEC_STEP);
        irq_lvl <= best_lvl;
      end
      // Return ends the deepest nesting level, even beside a take,
      // so that no return is lost
      if (irq_ret) begin
        if (insvc_r[2])
          insvc_r[2] <= 1'b0;
        else if (insvc_r[1])
          insvc_r[1] <= 1'b0;
        else
          insvc_r[0] <= 1'b0;
      end
      // A take marks its level last, so it outlives a return
      if (irq_ack && irq_req)
        insvc_r[irq_lvl - 2'h1] <= 1'b1;
    end
  end

  // ========================================================================
  // Pending flags
  // A new request in the clearing cycle survives: set wins.
  always @* begin
    pend_nxt = pend_r;
    if (reg_wr && reg_addr == `PIW_OFS_PEND)
      pend_nxt = pend_nxt & ~reg_wdata[28:0];
    pend_nxt = pend_nxt | src_all;
  end

  // ========================================================================
  // Standby mode
  // Wake terms for both hold modes; crystal hold adds the base timer.
  always @* begin
    wake_hold = !rp_s2_r ||
                (|(~(wk_s2_r ^ wpol_r))) ||
                pend_r[`PIW_SRC_PORT0];
    wake_x = wake_hold || pend_r[`PIW_SRC_BT0] ||
             pend_r[`PIW_SRC_BT1];
    mode_nxt = mode_r;
    case (mode_r)
      `PIW_MODE_RUN: begin
        if (reg_wr && reg_addr == `PIW_OFS_STANDBY)
          mode_nxt = reg_wdata[1:0];
      end
      `PIW_MODE_HALT: begin
        if (grant_ok)
          mode_nxt = `PIW_MODE_RUN;
      end
      `PIW_MODE_HOLD: begin
        if (wake_hold)
          mode_nxt = `PIW_MODE_RUN;
      end
      default: begin
        if (wake_x)
          mode_nxt = `PIW_MODE_RUN;
      end
    endcase
  end

  // Stop outputs are registered from the next mode so they track it
  always @(posedge core_clk) begin
    if (sys_rst) begin
      mode_r <= `PIW_MODE_RUN;
      cpu_stop <= 1'b0;
      periph_stop <= 1'b0;
      bt_stop <= 1'b0;
      osc_main_stop <= 1'b0;
      osc_xtal_stop <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      cpu_stop <= (mode_nxt != `PIW_MODE_RUN);
      periph_stop <= (mode_nxt == `PIW_MODE_HOLD) ||
                     (mode_nxt == `PIW_MODE_XHOLD);
      bt_stop <= (mode_nxt == `PIW_MODE_HOLD);
      osc_main_stop <= (mode_nxt == `PIW_MODE_HOLD) ||
                       (mode_nxt == `PIW_MODE_XHOLD);
      // Crystal keeps running in crystal hold, as on entry
      osc_xtal_stop <= (mode_nxt == `PIW_MODE_HOLD);
    end
  end

  // ========================================================================
  // Register writes
  always @(posedge core_clk) begin
    if (sys_rst) begin
      pend_r <= 29'h0000000;
      en_r <= `PIW_RST_ENABLE;
      lvl_r <= `PIW_RST_LEVEL;
      flt_r <= `PIW_RST_FILTER;
      wpol_r <= `PIW_RST_WAKEPOL;
    end else begin
      pend_r <= pend_nxt;
      if (reg_wr) begin
        if (reg_addr == `PIW_OFS_ENABLE)
          en_r <= reg_wdata[28:0];
        else if (reg_addr == `PIW_OFS_LEVEL)
          lvl_r <= reg_wdata[9:0];
        else if (reg_addr == `PIW_OFS_FILTER)
          flt_r <= reg_wdata[2:0];
        else if (reg_addr == `PIW_OFS_WAKEPOL)
          wpol_r <= reg_wdata[4:0];
      end
    end
  end

  // ========================================================================
  // Register reads
  // Data stand for one cycle only; unmapped addresses read zero.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_addr == `PIW_OFS_PEND) begin
      reg_rdata <= {3'h0, pend_r};
    end else if (reg_addr == `PIW_OFS_ENABLE) begin
      reg_rdata <= {3'h0, en_r};
    end else if (reg_addr == `PIW_OFS_LEVEL) begin
      reg_rdata <= {22'h000000, lvl_r};
    end else if (reg_addr == `PIW_OFS_STANDBY) begin
      reg_rdata <= {30'h00000000, mode_r};
    end else if (reg_addr == `PIW_OFS_FILTER) begin
      // Raw synchronised pin, never the filtered level
      reg_rdata <= {23'h000000, fp_s2_r, 5'h00, flt_r};
    end else if (reg_addr == `PIW_OFS_WAKEPOL) begin
      reg_rdata <= {27'h0000000, wpol_r};
    end else if (reg_addr == `PIW_OFS_STATUS) begin
      reg_rdata <= {23'h000000, filt_out, 2'h0, mode_r, 1'b0, insvc_r};
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // piw_top

// File: verification/piw_core_model.sv
/*
  Core model: takes a standing offer after a set lag, returns on request.
  Assumes the bench drives ack_en, lag and ret_go on core_clk.
*/
`timescale 1ns/1ns
module piw_core_model (
  input wire core_clk, // Clock
  input wire sys_rst, // Sync reset
  input wire irq_req, // Offer from the unit
  input wire ack_en, // Core may take offers
  input wire [1:0] lag, // Cycles before taking
  input wire ret_go, // Bench asks for a return
  output reg irq_ack, // Take pulse
  output reg irq_ret // Return pulse
);
// ==========================================================
// One take pulse per standing offer; slow when lag is large
reg [1:0] wait_r; // Cycles the offer has stood
always @(posedge core_clk) begin
  if (sys_rst) begin
    irq_ack <= 1'b0;
    irq_ret <= 1'b0;
    wait_r <= 2'h0;
  end else begin
    irq_ret <= ret_go;
    if (irq_ack || !irq_req || !ack_en) begin
      irq_ack <= 1'b0;
      wait_r <= 2'h0;
    end else if (wait_r == lag) irq_ack <= 1'b1;
    else wait_r <= wait_r + 2'h1;
  end
end
endmodule // piw_core_model

// File: verification/piw_properties.sv
/*
  Checker for piw_top: nesting, vector map and standby stop patterns.
  Assumes only the ports of piw_top; bound at the foot of this file.
*/
`timescale 1ns/1ns
module piw_properties (
  input wire core_clk, // Clock
  input wire sys_rst, // Sync reset
  input wire rst_pin_n, // Reset pin level
  input wire irq_ack, // Core take pulse
  input wire irq_ret, // Core return pulse
  input wire irq_req, // Offer to the core
  input wire [19:0] irq_addr, // Entry address
  input wire [1:0] irq_lvl, // Offered level
  input wire cpu_stop, // Execution halted
  input wire periph_stop, // Peripherals halted
  input wire bt_stop, // Base timer halted
  input wire osc_main_stop, // Main oscillators off
  input wire osc_xtal_stop // Crystal off
);
// ==========================================================
// Helper: level of the latest accepted vector
// Cleared on any return, so the nesting check only weakens
reg [1:0] svc_r; // Level in service
always @(posedge core_clk) begin
  if (sys_rst || irq_ret) svc_r <= 2'h0;
  else if (irq_req && irq_ack) svc_r <= irq_lvl;
end
// ==========================================================
// Sequences and properties
default clocking cb @(posedge core_clk); endclocking
default disable iff (sys_rst);
sequence s_take;
  irq_req && irq_ack;
endsequence
sequence s_pin_low;
  (osc_main_stop && !rst_pin_n) [*3];
endsequence
sequence s_halt_offer;
  cpu_stop && !periph_stop && irq_req;
endsequence
a_level_known: assert property (irq_req |-> irq_lvl != 2'h0)
  else $error("Offer without a level");
a_vector_map: assert property (irq_req |-> irq_addr[2:0] == 3'h3
  && irq_addr <= 20'h0004b) else $error("Entry address off map");
a_take_drops: assert property (s_take |=>
  !irq_req || irq_lvl > $past(irq_lvl)) else $error("Offer kept");
a_nest_block: assert property (irq_req && svc_r != 2'h0
  |-> irq_lvl > svc_r) else $error("Nested offer not higher");
a_halt_osc: assert property (cpu_stop && !periph_stop |->
  !osc_main_stop && !osc_xtal_stop && !bt_stop) else $error("Halt stops");
a_halt_wake: assert property (s_halt_offer |-> ##[0:2] !cpu_stop)
  else $error("Halt kept with offer");
a_hold_all: assert property (osc_xtal_stop |-> cpu_stop
  && periph_stop && bt_stop && osc_main_stop) else $error("Hold stops");
a_xhold_keep: assert property (osc_main_stop && !bt_stop |->
  cpu_stop && periph_stop && !osc_xtal_stop) else $error("Xtal hold");
a_pin_wake: assert property (s_pin_low |-> ##[0:4] !osc_main_stop)
  else $error("Reset pin did not wake");
endmodule // piw_properties
bind piw_top piw_properties u_prop (.core_clk(core_clk),
  .sys_rst(sys_rst), .rst_pin_n(rst_pin_n), .irq_ack(irq_ack),
  .irq_ret(irq_ret), .irq_req(irq_req), .irq_addr(irq_addr),
  .irq_lvl(irq_lvl), .cpu_stop(cpu_stop), .periph_stop(periph_stop),
  .bt_stop(bt_stop), .osc_main_stop(osc_main_stop),
  .osc_xtal_stop(osc_xtal_stop));

// File: verification/piw_top_bench.sv
/*
  Bench for piw_top: registers, arbitration, nesting, wake-up, filter.
  Assumes piw_regs.vh on the include path and the core model beside it.
*/
`timescale 1ns/1ns
`include "piw_regs.vh"
module piw_top_bench;
// ==========================================================
// Signals
reg core_clk = 1'b0; // 40 ns clock
reg sys_rst = 1'b1; // Reset, three cycles
reg [7:0] reg_addr = 8'h00; // Register address
reg [31:0] reg_wdata = 32'h0; // Write data
reg reg_wr = 1'b0; // Write strobe
reg reg_rd = 1'b0; // Read strobe
reg [28:0] src_req = 29'h0; // Source pulses
reg [4:0] wake_pin = 5'h1f; // Idle away from wake level
reg fpin = 1'b0; // Noisy pin
reg rst_pin_n = 1'b1; // Reset pin
reg ack_en = 1'b0; // Core may take
reg [1:0] lag = 2'h0; // Core take delay
reg ret_go = 1'b0; // Ask for a return
wire [31:0] reg_rdata;
wire irq_ack, irq_ret, irq_req, filt_out;
wire [19:0] irq_addr;
wire [1:0] irq_lvl;
wire cpu_stop, periph_stop, bt_stop, osc_main_stop, osc_xtal_stop;
wire [4:0] stops = {cpu_stop, periph_stop, bt_stop, osc_main_stop,
  osc_xtal_stop};
integer errors = 0, check_count = 0, i, k, m, n, lim, p;
reg [31:0] seed = 32'h393b651a; // Fixed seed, repeatable run
reg [9:0] lv;
reg [4:0] sa, sb, wp;
reg [3:0] va, vb, w, o;
reg [1:0] la, lb;
// First source of each vector, vector 0 in the low bits
localparam [49:0] FIRST = {5'h19, 5'h14, 5'h11, 5'h0e, 5'h0b, 5'h09,
  5'h05, 5'h02, 5'h01, 5'h00};
always #20 core_clk = ~core_clk;
piw_top uut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .src_req(src_req), .wake_pin(wake_pin),
  .filtered_ext_irq_pin(fpin), .rst_pin_n(rst_pin_n), .irq_ack(irq_ack),
  .irq_ret(irq_ret), .irq_req(irq_req), .irq_addr(irq_addr),
  .irq_lvl(irq_lvl), .filt_out(filt_out), .cpu_stop(cpu_stop),
  .periph_stop(periph_stop), .bt_stop(bt_stop),
  .osc_main_stop(osc_main_stop), .osc_xtal_stop(osc_xtal_stop));
piw_core_model core (.core_clk(core_clk), .sys_rst(sys_rst),
  .irq_req(irq_req), .ack_en(ack_en), .lag(lag), .ret_go(ret_go),
  .irq_ack(irq_ack), .irq_ret(irq_ret));
// ==========================================================
// Expectation helpers
function [31:0] xs(input [31:0] s);
  reg [31:0] t;
  begin
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  end
endfunction
function [3:0] vec_of(input [4:0] s);
  integer j;
  begin
    vec_of = 4'h0;
    for (j = 1; j < 10; j = j + 1)
      if (s >= FIRST[j*5 +: 5]) vec_of = j[3:0];
  end
endfunction
// Vectors 0 and 1 rise to the top level, the rest only to high
function [1:0] lvl_of(input [3:0] v, input [9:0] l);
  lvl_of = !l[v] ? `PIW_LVL_LOW : v < 2 ? `PIW_LVL_TOP : `PIW_LVL_HIGH;
endfunction
// ==========================================================
// Bus and handshake tasks
task complete_run;
  begin
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  end
endtask
task chk(input [31:0] seen, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  end
endtask
task cyc(input integer c);
  begin
    repeat (c) @(posedge core_clk);
    #1;
  end
endtask
task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  end
endtask
task rd(input [7:0] a, input [31:0] exp);
  begin
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  end
endtask
// Bounded wait: 0 offer up, 1 core take, 2 execution resumed
task wait_on(input [1:0] what);
  begin
    n = 0;
    while (n < 40 && !((what == 2'h0 && irq_req === 1'b1) ||
        (what == 2'h1 && irq_ack === 1'b1) ||
        (what == 2'h2 && cpu_stop === 1'b0))) begin
      cyc(1);
      n = n + 1;
    end
    if (n == 40) begin
      errors = errors + 1;
      complete_run;
    end
  end
endtask
task ret;
  begin
    @(posedge core_clk);
    ret_go <= 1'b1;
    @(posedge core_clk);
    ret_go <= 1'b0;
    cyc(2);
  end
endtask
// ==========================================================
// Main sequence
initial begin
  repeat (3) @(posedge core_clk);
  sys_rst <= 1'b0;
  for (i = 0; i < 8; i = i + 1) rd({i[5:0], 2'h0}, 32'h0);
  seed = xs(seed);
  wr(`PIW_OFS_LEVEL, seed);
  rd(`PIW_OFS_LEVEL, {22'h0, seed[9:0]});
  wr(8'h1c, seed);
  rd(8'h1c, 32'h0);
  wr(`PIW_OFS_ENABLE, 32'hffffffff);
  rd(`PIW_OFS_ENABLE, 32'h1fffffff);
  // Two sources at once; corners first, then random pairs
  for (i = 0; i < 40; i = i + 1) begin
    seed = xs(seed);
    lv = seed[9:0];
    sa = seed[14:10] % 29;
    sb = seed[20:16] % 29;
    lag <= seed[23:22];
    if (i < 2) begin
      sa = 5'h02;
      sb = 5'h1c;
      lv = i ? 10'h200 : 10'h000;
    end
    wr(`PIW_OFS_LEVEL, {22'h0, lv});
    @(posedge core_clk);
    src_req <= (29'h1 << sa) | (29'h1 << sb);
    @(posedge core_clk);
    src_req <= 29'h0;
    va = vec_of(sa);
    vb = vec_of(sb);
    la = lvl_of(va, lv);
    lb = lvl_of(vb, lv);
    w = (la > lb || (la == lb && va <= vb)) ? va : vb;
    o = (w == va) ? vb : va;
    wait_on(2'h0);
    chk(irq_addr, `PIW_VEC_BASE + `PIW_VEC_STEP * w);
    chk(irq_lvl, lvl_of(w, lv));
    rd(`PIW_OFS_PEND, (32'h1 << sa) | (32'h1 << sb));
    ack_en <= 1'b1;
    wait_on(2'h1);
    ack_en <= 1'b0;
    cyc(4);
    chk(irq_req, o != w && lvl_of(o, lv) > lvl_of(w, lv));
    if (o != w && irq_req === 1'b0) begin
      wr(`PIW_OFS_PEND, 32'h1 << ((w == va) ? sa : sb));
      ret;
      wait_on(2'h0);
      chk(irq_addr, `PIW_VEC_BASE + `PIW_VEC_STEP * o);
    end
    wr(`PIW_OFS_PEND, 32'h1fffffff);
    repeat (3) ret;
    rd(`PIW_OFS_PEND, 32'h0);
  end
  // Nesting: top vector interrupts a low one, a second low one waits
  wr(`PIW_OFS_LEVEL, 32'h1);
  for (k = 0; k < 3; k = k + 1) begin
    @(posedge core_clk);
    src_req <= 29'h1 << (k == 0 ? 2 : k == 1 ? 0 : 1);
    @(posedge core_clk);
    src_req <= 29'h0;
    cyc(3);
    chk(irq_req, k < 2);
    if (k < 2) begin
      chk(irq_lvl, k == 0 ? `PIW_LVL_LOW : `PIW_LVL_TOP);
      ack_en <= 1'b1;
      wait_on(2'h1);
      ack_en <= 1'b0;
      cyc(2);
    end
  end
  wr(`PIW_OFS_PEND, 32'h1fffffff);
  repeat (3) ret;
  // Halt keeps peripherals and clocks, ends on an offer
  wr(`PIW_OFS_STANDBY, `PIW_MODE_HALT);
  cyc(2);
  chk(stops, 5'h10);
  @(posedge core_clk);
  src_req <= 29'h1;
  @(posedge core_clk);
  src_req <= 29'h0;
  wait_on(2'h2);
  chk(irq_req, 1);
  // Halt entered under a standing offer ends at once
  wr(`PIW_OFS_STANDBY, `PIW_MODE_HALT);
  cyc(2);
  chk(stops, 5'h00);
  wr(`PIW_OFS_PEND, 32'h1fffffff);
  // Deep and crystal hold against each wake event
  wr(`PIW_OFS_ENABLE, 32'h0);
  seed = xs(seed);
  wp = seed[4:0];
  wr(`PIW_OFS_WAKEPOL, {27'h0, wp});
  wake_pin <= ~wp;
  for (m = 2; m < 4; m = m + 1)
    for (k = 0; k < 4; k = k + 1) begin
      wr(`PIW_OFS_STANDBY, m);
      cyc(3);
      chk(stops, m == 2 ? 5'h1f : 5'h1a);
      seed = xs(seed);
      p = seed % 5;
      @(posedge core_clk);
      if (k == 0) rst_pin_n <= 1'b0;
      if (k == 1) wake_pin[p] <= wp[p];
      if (k == 2) src_req <= 29'h1 << `PIW_SRC_PORT0;
      if (k == 3) src_req <= 29'h1 << `PIW_SRC_BT0;
      @(posedge core_clk);
      src_req <= 29'h0;
      cyc(8);
      chk(cpu_stop, m == 2 && k == 3);
      // Reset pin always frees a stuck deep hold
      rst_pin_n <= 1'b0;
      wake_pin <= ~wp;
      cyc(6);
      rst_pin_n <= 1'b1;
      cyc(3);
      wr(`PIW_OFS_PEND, 32'h1fffffff);
    end
  // Filter: raw level readable at once, output only after the limit
  for (k = 0; k < 3; k = k + 1) begin
    lim = k == 0 ? `PIW_FLT_CYC0 : k == 1 ? `PIW_FLT_CYC1 : `PIW_FLT_CYC2;
    wr(`PIW_OFS_FILTER, 32'h4 | k);
    @(posedge core_clk);
    fpin <= 1'b1;
    cyc(3);
    rd(`PIW_OFS_FILTER, 32'h104 | k);
    if (k > 0) chk(filt_out, 0);
    n = 5;
    while (filt_out !== 1'b1 && n < 200) begin
      cyc(1);
      n = n + 1;
    end
    chk(n >= lim && n <= lim + 6, 1);
    fpin <= 1'b0;
    cyc(lim + 8);
    chk(filt_out, 0);
  end
  complete_run;
end
endmodule // piw_top_bench
